// ---- vectored_priority_interrupt_unit.sv ----
// Operation
// - Taking an interrupt pushes instruction pointer and status word to a memory stack.
// - Highest source in highest level wins; sources share levels.
// - External request accepted only when its level exceeds the run level.
// - Push status, push pointer, address vector, load pointer then status.
// - Return instruction pops and restores pointer and status, hence priority.
// - Vector run level zero keeps current run level, loads other bits.
// - Loaded run level blocks that level and lower, admits higher.
// - Run level seven blocks all external; higher levels merge groups.
// - Internal requests one at a time, unmaskable, always taken, cleared.
// - Internal first; then nested external entry if vector level is lower.
// - Source identified in hardware, vector chosen without polling.
// - Thirty-two parallel-bus sources and sixteen serial-bus sources accepted.
// - Internal vectors at 4-byte slots from 0000, externals at 00c0-00fc.
// - Level 2 selects alternate bank, 1 is main, 0 means no change.
// - Vector run level can group several request levels together.
// - Run level lives in status word bits 6 to 4.
// - General register 15 is the stack pointer.
// - Unprivileged device access or system instruction raises an internal request.
module vectored_priority_interrupt_unit #(
  parameter logic [vpiu_pkg::LVL_W-1:0] EXT_LEVEL = 3'h3
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [vpiu_pkg::N_INT-1:0] int_req,
  input wire logic [vpiu_pkg::N_PAR_SRC-1:0] par_req,
  input wire logic [vpiu_pkg::N_SER_SRC-1:0] ser_req,
  input wire logic priv_violation,
  input wire logic return_from_service_instr,
  input wire logic [vpiu_pkg::WORD_W-1:0] cur_instruction_pointer,
  output logic [vpiu_pkg::WORD_W-1:0] status_word_reg,
  output logic [vpiu_pkg::WORD_W-1:0] instruction_pointer,
  output logic ip_load,
  output logic mem_req,
  output logic mem_we,
  output logic [vpiu_pkg::WORD_W-1:0] mem_addr,
  output logic [vpiu_pkg::WORD_W-1:0] mem_wdata,
  input wire logic [vpiu_pkg::WORD_W-1:0] mem_rdata,
  input wire logic mem_ack,
  output logic [vpiu_pkg::WORD_W-1:0] stack_ptr,
  output logic alt_bank_sel,
  output logic in_service,
  output logic [5:0] ext_ack_src,
  output logic ext_ack
);
  import vpiu_pkg::*;

  vpiu_state_e state_q;
  logic [WORD_W-1:0] sp_q, sw_q, ip_q, vec_q, addr_q, wdata_q;
  logic [N_INT-1:0] int_pend_q;
  logic ip_load_q, ext_ack_q, we_q, req_q;
  logic [5:0] ack_src_q;
  logic [LVL_W-1:0] run_level;
  logic int_any, ext_any, take_int, take_ext, start;
  logic [2:0] int_idx;
  logic [3:0] ext_idx;
  logic [N_EXT-1:0] ext_lines;
  logic [N_EXT-1:0] ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;
  logic [N_INT-1:0] int_src;

  assign run_level = sw_q[RUN_HI:RUN_LO];

  // Internal conditions latch until taken; set beats clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      int_pend_q <= '0;
    end else begin
      int_pend_q <= (take_int && state_q == VPIU_IDLE ?
                     int_pend_q & ~(N_INT'(1) << int_idx) : int_pend_q)
                    | int_req | (N_INT'(priv_violation) << INT_PRIV);
    end
  end

  // Bus sources fold onto sixteen external lines; 48 sources accepted
  always_comb begin
    ext_lines = '0;
    for (int i = 0; i < N_EXT; i++) begin
      ext_lines[i] = par_req[i] | par_req[i+N_EXT] | ser_req[i];
    end
  end

  // Bus requests come from other clock domains: three stages, and a line only
  // moves once stages two and three agree, so a one-beat glitch never starts entry
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      ext_s3_q <= '0;
      ext_lvl_q <= '0;
    end else begin
      ext_s1_q <= ext_lines;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      ext_lvl_q <= (ext_s2_q & ext_s3_q) | (ext_lvl_q & (ext_s2_q | ext_s3_q));
    end
  end

  // Internal source 0 (power down) ranks highest, so reverse for the arbiter
  always_comb begin
    int_src = '0;
    for (int i = 0; i < N_INT; i++) begin
      int_src[N_INT-1-i] = int_pend_q[i];
    end
  end

  logic [2:0] int_rev;
  vpiu_arbiter #(.N(N_INT), .W(3)) u_int_arb (
    .req(int_src),
    .any(int_any),
    .idx(int_rev)
  );
  assign int_idx = 3'(N_INT - 1) - int_rev;

  vpiu_arbiter #(.N(N_EXT), .W(4)) u_ext_arb (
    .req(ext_lvl_q),
    .any(ext_any),
    .idx(ext_idx)
  );

  assign take_int = int_any;
  assign take_ext = ext_any && (EXT_LEVEL > run_level);
  assign start = take_int || take_ext;

  // Entry and return sequencer over the stack port
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_q <= VPIU_IDLE;
      sp_q <= SP_RST;
      sw_q <= STATUS_RST;
      ip_q <= '0;
      vec_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      we_q <= 1'b0;
      req_q <= 1'b0;
      ip_load_q <= 1'b0;
      ext_ack_q <= 1'b0;
      ack_src_q <= '0;
    end else begin
      ip_load_q <= 1'b0;
      ext_ack_q <= 1'b0;
      case (state_q)
        VPIU_IDLE: begin
          if (start) begin
            // Internal wins; a nested external entry follows once IDLE returns
            vec_q <= take_int ? TV_INT_BASE + WORD_W'(int_idx) * TV_SLOT
                              : TV_EXT_BASE + WORD_W'(4'hf - ext_idx) * TV_SLOT;
            ext_ack_q <= !take_int;
            ack_src_q <= take_int ? 6'h00 : {2'h0, ext_idx};
            ip_q <= cur_instruction_pointer;
            addr_q <= sp_q - WORD_STEP;
            sp_q <= sp_q - WORD_STEP;
            wdata_q <= sw_q;
            we_q <= 1'b1;
            req_q <= 1'b1;
            state_q <= VPIU_PUSH_SW;
          end else if (return_from_service_instr) begin
            addr_q <= sp_q;
            we_q <= 1'b0;
            req_q <= 1'b1;
            state_q <= VPIU_POP_IP;
          end
        end
        VPIU_PUSH_SW: if (mem_ack) begin
          addr_q <= sp_q - WORD_STEP;
          sp_q <= sp_q - WORD_STEP;
          wdata_q <= ip_q;
          state_q <= VPIU_PUSH_IP;
        end
        VPIU_PUSH_IP: if (mem_ack) begin
          addr_q <= vec_q;
          we_q <= 1'b0;
          state_q <= VPIU_FETCH_IP;
        end
        VPIU_FETCH_IP: if (mem_ack) begin
          ip_q <= mem_rdata;
          ip_load_q <= 1'b1;
          addr_q <= vec_q + WORD_STEP;
          state_q <= VPIU_FETCH_SW;
        end
        VPIU_FETCH_SW: if (mem_ack) begin
          // Level zero in the vector keeps the running level
          sw_q <= (mem_rdata[RUN_HI:RUN_LO] == LVL_NOCHANGE) ?
                  {mem_rdata[WORD_W-1:RUN_HI+1], run_level, mem_rdata[RUN_LO-1:0]}
                  : mem_rdata;
          req_q <= 1'b0;
          state_q <= VPIU_WAIT;
        end
        VPIU_POP_IP: if (mem_ack) begin
          ip_q <= mem_rdata;
          ip_load_q <= 1'b1;
          sp_q <= sp_q + WORD_STEP;
          addr_q <= sp_q + WORD_STEP;
          state_q <= VPIU_POP_SW;
        end
        VPIU_POP_SW: if (mem_ack) begin
          sw_q <= mem_rdata;
          sp_q <= sp_q + WORD_STEP;
          req_q <= 1'b0;
          state_q <= VPIU_WAIT;
        end
        VPIU_WAIT: state_q <= VPIU_IDLE; // One idle beat lets new status settle
        default: state_q <= VPIU_IDLE;
      endcase
    end
  end

  assign status_word_reg = sw_q;
  assign instruction_pointer = ip_q;
  assign ip_load = ip_load_q;
  assign mem_req = req_q;
  assign mem_we = we_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
  assign stack_ptr = sp_q;
  assign alt_bank_sel = (run_level == LVL_ALTBANK);
  assign in_service = (state_q != VPIU_IDLE);
  assign ext_ack_src = ack_src_q;
  assign ext_ack = ext_ack_q;

  a_ext_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == VPIU_IDLE && ext_any && !int_any && run_level >= EXT_LEVEL)
    |=> state_q == VPIU_IDLE || $past(return_from_service_instr))
    else $error("External entry below run level");
  a_int_first: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == VPIU_IDLE && int_any) |=> state_q == VPIU_PUSH_SW && !ext_ack)
    else $error("Internal request not entered first");
  a_push_dec: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == VPIU_IDLE && start) |=> sp_q == $past(sp_q) - WORD_STEP)
    else $error("Stack pointer not predecremented");
  a_pop_inc: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == VPIU_POP_SW && mem_ack) |=> sp_q == $past(sp_q) + WORD_STEP)
    else $error("Stack pointer not restored on return");
  a_keep_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == VPIU_FETCH_SW && mem_ack && mem_rdata[RUN_HI:RUN_LO] == LVL_NOCHANGE)
    |=> run_level == $past(run_level))
    else $error("Zero vector level changed run level");
  a_load_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == VPIU_FETCH_SW && mem_ack && mem_rdata[RUN_HI:RUN_LO] != LVL_NOCHANGE)
    |=> run_level == $past(mem_rdata[RUN_HI:RUN_LO]))
    else $error("Vector level not loaded");
  a_push_order: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == VPIU_PUSH_SW && mem_ack) |=> mem_wdata == ip_q && mem_we)
    else $error("Pointer push out of order");
  a_vec_range: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == VPIU_FETCH_IP) |->
    (mem_addr < TV_INT_BASE + WORD_W'(N_INT) * TV_SLOT ||
     (mem_addr >= TV_EXT_BASE &&
      mem_addr <= TV_EXT_BASE + WORD_W'(N_EXT - 1) * TV_SLOT)))
    else $error("Vector address outside slots");
  a_int_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q == VPIU_IDLE && int_any && !int_req[int_idx] &&
     !(priv_violation && int_idx == 3'(INT_PRIV))) |=> !int_pend_q[$past(int_idx)])
    else $error("Taken internal request not cleared");
endmodule

// ---- vpiu_pkg.sv ----
package vpiu_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned LVL_W = 3;
  localparam int unsigned RUN_LO = 4;
  localparam int unsigned RUN_HI = 6;
  localparam int unsigned PRIV_BIT = 15;
  localparam logic [LVL_W-1:0] LVL_NOCHANGE = 3'h0;
  localparam logic [LVL_W-1:0] LVL_MAIN = 3'h1;
  localparam logic [LVL_W-1:0] LVL_ALTBANK = 3'h2;
  localparam logic [LVL_W-1:0] LVL_ALL_MASK = 3'h7;
  localparam int unsigned N_INT = 5;
  localparam int unsigned N_EXT = 16;
  localparam int unsigned N_PAR_SRC = 32;
  localparam int unsigned N_SER_SRC = 16;
  localparam logic [WORD_W-1:0] TV_INT_BASE = 16'h0000;
  localparam logic [WORD_W-1:0] TV_EXT_BASE = 16'h00c0;
  localparam logic [WORD_W-1:0] TV_SLOT = 16'h0004;
  localparam logic [WORD_W-1:0] WORD_STEP = 16'h0002;
  localparam logic [WORD_W-1:0] STATUS_RST = 16'h8010;
  localparam logic [WORD_W-1:0] SP_RST = 16'h0000;
  localparam int unsigned INT_PRIV = 3;
  typedef enum logic [3:0] {
    VPIU_IDLE = 4'h0, VPIU_PUSH_SW = 4'h1, VPIU_PUSH_IP = 4'h3, VPIU_FETCH_IP = 4'h2,
    VPIU_FETCH_SW = 4'h6, VPIU_POP_IP = 4'h4, VPIU_POP_SW = 4'h5, VPIU_WAIT = 4'h7
  } vpiu_state_e;
endpackage

// ---- vpiu_arbiter.sv ----
// Fixed-priority pick: the highest index that is requesting wins
module vpiu_arbiter #(
  parameter int unsigned N = 16,
  parameter int unsigned W = 4
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [W-1:0] idx
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i]) begin
        any = 1'b1;
        idx = W'(i);
      end
    end
  end
endmodule

// ---- vpiu_mem_model.sv ----
// Stack and vector memory answering the unit's memory port
module vpiu_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [1:0] lat,
  output logic [15:0] rdata,
  output logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // Byte-addressed for simple probing; only words the bench preloads or the unit writes are read
  logic [15:0] mem [0:65535];
  logic [1:0] cnt_q;
  // Ack after lat wait cycles; rdata toggles while not valid so stale data never matches
  always @(posedge clk) begin
    if (!rst_b) begin
      ack <= 1'b0;
      cnt_q <= 2'h0;
      rdata <= 16'h0000;
    end else if (req && !ack && cnt_q == lat) begin
      ack <= 1'b1;
      cnt_q <= 2'h0;
      if (we) mem[addr] <= wdata;
      rdata <= mem[addr];
    end else begin
      ack <= 1'b0;
      cnt_q <= (req && !ack) ? cnt_q + 2'h1 : 2'h0;
      rdata <= ~rdata;
    end
  end
endmodule

// ---- tb_top.sv ----
module tb_top import vpiu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_b, ip_load, mem_req, mem_we, mem_ack, alt_bank_sel, in_service, ext_ack;
  logic ret, priv;
  logic [4:0] int_req;
  logic [31:0] par_req;
  logic [15:0] ser_req, cur_ip, sw, ip, mem_addr, mem_wdata, mem_rdata, sp, v;
  logic [5:0] ext_src;
  logic [1:0] lat;
  int n_fail = 0, compares = 0, cyc = 0;
  vectored_priority_interrupt_unit vectored_priority_interrupt_unit_i (.core_clk(core_clk),
    .rst_b(rst_b), .int_req(int_req), .par_req(par_req), .ser_req(ser_req),
    .priv_violation(priv), .return_from_service_instr(ret), .cur_instruction_pointer(cur_ip),
    .status_word_reg(sw), .instruction_pointer(ip), .ip_load(ip_load), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .stack_ptr(sp), .alt_bank_sel(alt_bank_sel), .in_service(in_service),
    .ext_ack_src(ext_src), .ext_ack(ext_ack));
  vpiu_mem_model vpiu_mem_model_i (.clk(core_clk), .rst_b(rst_b), .req(mem_req), .we(mem_we),
    .addr(mem_addr), .wdata(mem_wdata), .lat(lat), .rdata(mem_rdata), .ack(mem_ack));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Cut a hang short; the whole run needs well under this
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Wait for a new pointer load, bounded
  task automatic wait_ip(output logic [15:0] val);
    val = 16'hdead;
    for (int i = 0; i < 100 && ip_load !== 1'b1; i++) tick(1);
    if (ip_load === 1'b1) val = ip;
    tick(1);
  endtask
  // Wait for the external acknowledge, bounded, and check the line it names
  task automatic wait_ack(input logic [5:0] src);
    for (int i = 0; i < 100 && ext_ack !== 1'b1; i++) tick(1);
    chk({15'h0, ext_ack}, 16'h0001);
    chk({10'h0, ext_src}, {10'h0, src});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100 && in_service !== 1'b0; i++) tick(1);
  endtask
  task automatic do_ret();
    ret = 1'b1;
    tick(1);
    ret = 1'b0;
    tick(2);
    wait_idle();
  endtask
  // Two external lines at once, blocking by the new run level, then return
  task automatic t_ext();
    lat = 2'h2;
    par_req[5] = 1'b1;
    par_req[18] = 1'b1;
    wait_ack(6'h05);
    wait_ip(v);
    chk(v, 16'h1234);
    wait_idle();
    chk(sw, 16'h0050);
    chk({10'h0, ext_src}, 16'h0005);
    chk(vpiu_mem_model_i.mem[16'hfffe], STATUS_RST);
    chk(vpiu_mem_model_i.mem[16'hfffc], 16'h0a00);
    chk(sp, 16'hfffc);
    par_req[5] = 1'b0;
    tick(20);
    chk({15'h0, in_service}, 16'h0000);
    lat = 2'h0;
    do_ret();
    chk(sw, STATUS_RST);
    chk(sp, 16'h0000);
    chk(ip, 16'h0a00);
    wait_ack(6'h02);
    par_req[18] = 1'b0;
    wait_ip(v);
    chk(v, 16'h2222);
    wait_idle();
    chk(sw, 16'h0010);
    do_ret();
    $display("test ext done");
  endtask
  // Internal and external together: internal first, external nests after
  task automatic t_nest();
    int_req[2] = 1'b1;
    ser_req[4] = 1'b1;
    tick(1);
    int_req[2] = 1'b0;
    wait_ip(v);
    chk(v, 16'h3300);
    wait_ack(6'h04);
    ser_req[4] = 1'b0;
    wait_ip(v);
    chk(v, 16'h4400);
    wait_idle();
    chk(vpiu_mem_model_i.mem[16'hfffa], 16'h0010);
    chk(sp, 16'hfff8);
    chk(sw, 16'h0060);
    do_ret();
    chk(sw, 16'h0010);
    do_ret();
    chk(sw, STATUS_RST);
    chk(sp, 16'h0000);
    $display("test nest done");
  endtask
  // Privilege fault enters through its own slot; its vector selects the alternate bank
  task automatic t_int();
    priv = 1'b1;
    tick(1);
    priv = 1'b0;
    wait_ip(v);
    chk(v, 16'h5500);
    wait_idle();
    chk(sw, 16'h0020);
    chk({15'h0, alt_bank_sel}, 16'h0001);
    do_ret();
    chk({15'h0, alt_bank_sel}, 16'h0000);
    chk(sw, STATUS_RST);
    chk(ip, 16'h0a00);
    $display("test int done");
  endtask
  task automatic close_out();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    ret = 1'b0;
    priv = 1'b0;
    int_req = 5'h00;
    par_req = 32'h0;
    ser_req = 16'h0;
    cur_ip = 16'h0a00;
    lat = 2'h0;
    // Vectors: line 5, line 2, internal 2, line 4, privilege fault
    vpiu_mem_model_i.mem[16'h00e8] = 16'h1234;
    vpiu_mem_model_i.mem[16'h00ea] = 16'h0050;
    vpiu_mem_model_i.mem[16'h00f4] = 16'h2222;
    vpiu_mem_model_i.mem[16'h00f6] = 16'h0000;
    vpiu_mem_model_i.mem[16'h0008] = 16'h3300;
    vpiu_mem_model_i.mem[16'h000a] = 16'h0000;
    vpiu_mem_model_i.mem[16'h00ec] = 16'h4400;
    vpiu_mem_model_i.mem[16'h00ee] = 16'h0060;
    vpiu_mem_model_i.mem[16'h000c] = 16'h5500;
    vpiu_mem_model_i.mem[16'h000e] = 16'h0020;
    tick(10);
    rst_b = 1'b1;
    chk(sw, STATUS_RST);
    chk(sp, SP_RST);
    t_ext();
    t_nest();
    t_int();
    close_out();
  end
endmodule
